//--- verilog/clock_config_cfg.svh
// Purpose: Decoder constants
// Assumes: Aligned 32-bit registers
// Notes:   Byte offsets
`ifndef CLOCK_CONFIG_CFG_SVH
`define CLOCK_CONFIG_CFG_SVH

// Configuration word layout
`define CFG_WORD_W          24
`define CFG_TWO_SPEED_BIT   15
`define CFG_RSVD_HI_MSB     23
`define CFG_RSVD_HI_LSB     16
`define CFG_RSVD_LO_MSB     14
`define CFG_RSVD_LO_LSB     11
`define CFG_OSC_SEL_MSB     10
`define CFG_OSC_SEL_LSB     8
`define CFG_CLK_SW_MSB      7
`define CFG_CLK_SW_LSB      6
`define CFG_OSC_PIN_FN_BIT  5
`define CFG_ONE_WAY_BIT     4
`define CFG_TWOWIRE_BIT     2
`define CFG_PRI_MODE_MSB    1
`define CFG_PRI_MODE_LSB    0

// Register offsets
`define OFF_CFG_WORD        12'h000
`define OFF_DECODE_STATUS   12'h004
`define OFF_LOCK_CTRL       12'h008
`define OFF_UNLOCK_KEY      12'h00C
`define OFF_PIN_SELECT      12'h010
`define OFF_GPIO_CTRL       12'h014

// Decode status field positions
`define ST_SRC_LSB          0
`define ST_USE_PLL_BIT      3
`define ST_POSTSCALE_BIT    4
`define ST_SRC_RSVD_BIT     5
`define ST_TWO_SPEED_BIT    6
`define ST_CLK_SW_BIT       7
`define ST_MON_BIT          8
`define ST_PIN_CLK_BIT      9
`define ST_PIN_GPIO_BIT     10
`define ST_TWOWIRE_BIT      11
`define ST_ONE_WAY_BIT      12
`define ST_LOCK_BIT         13
`define ST_ARMED_BIT        14

// Lock and gpio fields
`define LOCK_BIT            0
`define GPIO_OUT_BIT        0
`define GPIO_OE_BIT         1
`define GPIO_IN_BIT         2

// Unlock keys, written back to back
`define UNLOCK_KEY1         32'h0000_46A5
`define UNLOCK_KEY2         32'h0000_57B6

// Reset values
`define RST_PIN_SELECT      32'h0000_0000
`define RST_WORD            32'h0000_0000

`endif

//--- verilog/clock_config_pkg.sv
// Purpose: Types for the clock configuration word decoder
// Assumes: Nothing beyond the cfg header
// Notes:   Constants live in clock_config_cfg.svh
package clock_config_pkg;

   // Initial oscillator select codes
   typedef enum logic [2:0] {
      SRC_FAST_RC          = 3'b000,
      SRC_FAST_RC_POST_PLL = 3'b001,
      SRC_PRIMARY          = 3'b010,
      SRC_PRIMARY_PLL      = 3'b011,
      SRC_SECONDARY        = 3'b100,
      SRC_LOW_POWER_RC     = 3'b101,
      SRC_RESERVED         = 3'b110,
      SRC_FAST_RC_POST     = 3'b111
   } osc_src_t;

   // Unlock sequence states
   typedef enum logic [1:0] {
      UNL_IDLE  = 2'b00,
      UNL_KEY1  = 2'b01,
      UNL_ARMED = 2'b10
   } unlock_state_t;

endpackage : clock_config_pkg

//--- verilog/clock_config_word_decoder.sv
// Purpose: Latch and decode the clock configuration word
// Assumes: mclk is the system clock; cfg_word stable at reset
// Notes:   APB slave, no wait states
// Functional notes
// R1: Bit 15 enables two-speed start-up.
// R2: Bits 23-16 and 14-11 reserved, unused.
// R3: Select field bits 10-8; 111 is postscaled fast RC.
// R4: Select code 110 reserved, no source.
// R5: Code 101: low-power RC.
// R6: Code 100: secondary oscillator.
// R7: Code 011: primary oscillator with PLL.
// R8: Code 010: primary oscillator, no PLL.
// R9: Code 001: postscaled fast RC with PLL.
// R10: Code 000: fast RC, no postscaler, no PLL.
// R11: Bits 7-6; upper bit set disables switching and monitor.
// R12: Field 01: switching on, monitor off.
// R13: Field 00: switching and monitor on.
// R14: Bit 5 honoured only in primary modes 11 and 00.
// R15: Honoured bit 5 set: pin carries clock halved.
// R16: Honoured bit 5 clear: pin is general-purpose port bit.
// R17: Primary modes 10 and 01 ignore bit 5.
// R18: One-way: lock sets once after unlock; then pin-select writes refused.
// R19: Else lock sets and clears, each after unlock.
// R20: Bit 2 set routes second two-wire port to primary pins.
// R21: Word latched at reset, decode held until next reset.
`include "clock_config_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module clock_config_word_decoder #(
   parameter int CFG_WIDTH = `CFG_WORD_W,
   parameter int PPS_WIDTH = 32
) (
   // Clock and reset
   input  wire  logic                       mclk,
   input  wire  logic                       nrst,
   // Nonvolatile configuration word
   input  wire  logic [CFG_WIDTH-1:0]       cfg_word,
   // APB slave
   input  wire  logic                       psel,
   input  wire  logic                       penable,
   input  wire  logic                       pwrite,
   input  wire  logic [11:0]                paddr,
   input  wire  logic [31:0]                pwdata,
   output logic       [31:0]                prdata,
   output logic                             pready,
   output logic                             pslverr,
   // Decoded oscillator selection
   output logic       [2:0]                 initial_osc_select,
   output logic                             src_use_pll,
   output logic                             src_use_postscaler,
   output logic                             src_reserved,
   output logic                             two_speed_startup_en,
   output logic                             clk_switch_en,
   output logic                             fail_safe_mon_en,
   // Oscillator-output pin
   input  wire  logic                       osc_output_pin_in,
   output logic                             osc_output_pin_out,
   output logic                             osc_output_pin_oe,
   // Pin mux
   output logic                             second_twowire_pin_choice,
   output logic                             pin_select_lock,
   output logic       [PPS_WIDTH-1:0]       pin_select_value
);

   initial begin
      if (CFG_WIDTH != `CFG_WORD_W) begin
         $error("CFG_WIDTH must be 24");
      end
      if (PPS_WIDTH < 1 || PPS_WIDTH > 32) begin
         $error("PPS_WIDTH must be 1 to 32");
      end
   end

   // Configuration capture
   logic [CFG_WIDTH-1:0] cfg_reg;
   logic                 cfg_valid_reg;

   // Captured one edge after release
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         cfg_valid_reg <= 1'b0;
      end else begin
         cfg_valid_reg <= 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         cfg_reg <= '0;
      end else if (!cfg_valid_reg) begin
         cfg_reg <= cfg_word; // R21
      end
   end

   // Field extraction; reserved bits 23-16 and 14-11 are only read back, never decoded
   wire       two_speed_bit = cfg_reg[`CFG_TWO_SPEED_BIT]; // R1 R2
   wire [2:0] osc_sel_fld   = cfg_reg[`CFG_OSC_SEL_MSB:`CFG_OSC_SEL_LSB]; // R3
   wire [1:0] clk_sw_fld    = cfg_reg[`CFG_CLK_SW_MSB:`CFG_CLK_SW_LSB]; // R11
   wire       pin_fn_bit    = cfg_reg[`CFG_OSC_PIN_FN_BIT];
   wire       one_way_bit   = cfg_reg[`CFG_ONE_WAY_BIT];
   wire       twowire_bit   = cfg_reg[`CFG_TWOWIRE_BIT];
   wire [1:0] pri_mode_fld  = cfg_reg[`CFG_PRI_MODE_MSB:`CFG_PRI_MODE_LSB];

   // Oscillator source decode
   clock_config_pkg::osc_src_t src_dec;
   logic                       pll_dec;
   logic                       post_dec;
   logic                       rsvd_dec;

   always_comb begin
      src_dec  = clock_config_pkg::osc_src_t'(osc_sel_fld);
      pll_dec  = 1'b0;
      post_dec = 1'b0;
      rsvd_dec = 1'b0;
      case (osc_sel_fld)
         3'b111: begin
            post_dec = 1'b1; // R3
         end
         3'b110: begin
            rsvd_dec = 1'b1; // R4
         end
         3'b101: begin
            pll_dec = 1'b0; // R5
         end
         3'b100: begin
            pll_dec = 1'b0; // R6
         end
         3'b011: begin
            pll_dec = 1'b1; // R7
         end
         3'b010: begin
            pll_dec = 1'b0; // R8
         end
         3'b001: begin
            pll_dec  = 1'b1; // R9
            post_dec = 1'b1; // R9
         end
         3'b000: begin
            pll_dec = 1'b0; // R10
         end
         default: begin
            rsvd_dec = 1'b1;
         end
      endcase
   end

   // Switching and monitor decode
   wire sw_dec  = ~clk_sw_fld[1]; // R11 R12 R13
   wire mon_dec = (clk_sw_fld == 2'b00); // R11 R12 R13

   // Pin function: honoured only in primary modes 11 and 00
   wire pin_honoured = (pri_mode_fld == 2'b11) || (pri_mode_fld == 2'b00); // R14 R17
   wire pin_clk_dec  = pin_honoured & pin_fn_bit; // R15
   wire pin_gpio_dec = pin_honoured & ~pin_fn_bit; // R16

   // Decoded outputs, frozen once the word is captured
   logic [2:0] src_reg;
   logic       pll_reg;
   logic       post_reg;
   logic       rsvd_reg;
   logic       two_speed_reg;
   logic       sw_reg;
   logic       mon_reg;
   logic       pin_clk_reg;
   logic       pin_gpio_reg;
   logic       twowire_reg;
   logic       one_way_reg;

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         src_reg       <= 3'h0;
         pll_reg       <= 1'b0;
         post_reg      <= 1'b0;
         rsvd_reg      <= 1'b0;
         two_speed_reg <= 1'b0;
         sw_reg        <= 1'b0;
         mon_reg       <= 1'b0;
         pin_clk_reg   <= 1'b0;
         pin_gpio_reg  <= 1'b0;
         twowire_reg   <= 1'b0;
         one_way_reg   <= 1'b0;
      end else begin
         src_reg       <= src_dec;
         pll_reg       <= pll_dec;
         post_reg      <= post_dec;
         rsvd_reg      <= rsvd_dec;
         two_speed_reg <= two_speed_bit; // R1
         sw_reg        <= sw_dec;
         mon_reg       <= mon_dec;
         pin_clk_reg   <= pin_clk_dec;
         pin_gpio_reg  <= pin_gpio_dec;
         twowire_reg   <= twowire_bit; // R20
         one_way_reg   <= one_way_bit;
      end
   end

   // APB decode
   wire apb_setup  = psel & ~penable;
   wire apb_access = psel & penable;
   wire wr_xfer    = apb_access & pwrite;
   wire hit_cfg    = (paddr == `OFF_CFG_WORD);
   wire hit_status = (paddr == `OFF_DECODE_STATUS);
   wire hit_lock   = (paddr == `OFF_LOCK_CTRL);
   wire hit_key    = (paddr == `OFF_UNLOCK_KEY);
   wire hit_pps    = (paddr == `OFF_PIN_SELECT);
   wire hit_gpio   = (paddr == `OFF_GPIO_CTRL);
   wire hit_any    = hit_cfg | hit_status | hit_lock | hit_key | hit_pps | hit_gpio;

   // Unlock sequence: key1 then key2 as consecutive writes arms one lock write
   clock_config_pkg::unlock_state_t unl_reg;
   clock_config_pkg::unlock_state_t unl_next;
   logic                            lock_reg;
   logic                            lock_next;
   logic                            lock_refused;

   wire key_wr    = wr_xfer & hit_key;
   wire lock_wr   = wr_xfer & hit_lock;
   wire lock_want = pwdata[`LOCK_BIT];
   wire armed     = (unl_reg == clock_config_pkg::UNL_ARMED);

   always_comb begin
      unl_next = unl_reg;
      case (unl_reg)
         clock_config_pkg::UNL_IDLE: begin
            if (key_wr && pwdata == `UNLOCK_KEY1) begin
               unl_next = clock_config_pkg::UNL_KEY1;
            end
         end
         clock_config_pkg::UNL_KEY1: begin
            if (key_wr && pwdata == `UNLOCK_KEY2) begin
               unl_next = clock_config_pkg::UNL_ARMED;
            end else if (wr_xfer) begin
               unl_next = clock_config_pkg::UNL_IDLE;
            end
         end
         clock_config_pkg::UNL_ARMED: begin
            // Any write spends the unlock, so a stray write cannot leave it open
            if (wr_xfer) begin
               unl_next = clock_config_pkg::UNL_IDLE;
            end
         end
         default: begin
            unl_next = clock_config_pkg::UNL_IDLE;
         end
      endcase
   end

   always_comb begin
      lock_next    = lock_reg;
      lock_refused = 1'b0;
      if (lock_wr && lock_want != lock_reg) begin
         if (!armed) begin
            lock_refused = 1'b1; // R18 R19
         end else if (one_way_reg && !lock_want) begin
            lock_refused = 1'b1; // R18
         end else begin
            lock_next = lock_want; // R18 R19
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         unl_reg  <= clock_config_pkg::UNL_IDLE;
         lock_reg <= 1'b0;
      end else begin
         unl_reg  <= unl_next;
         lock_reg <= lock_next;
      end
   end

   // Pin-select register, refused once locked
   logic [PPS_WIDTH-1:0] pps_reg;
   wire                  pps_wr      = wr_xfer & hit_pps;
   wire                  pps_refused = pps_wr & lock_reg; // R18

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         pps_reg <= PPS_WIDTH'(`RST_PIN_SELECT);
      end else if (pps_wr && !lock_reg) begin
         pps_reg <= pwdata[PPS_WIDTH-1:0];
      end
   end

   // General-purpose port bit on the oscillator-output pin
   logic gpio_out_reg;
   logic gpio_oe_reg;
   wire  gpio_wr = wr_xfer & hit_gpio;

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         gpio_out_reg <= 1'b0;
         gpio_oe_reg  <= 1'b0;
      end else if (gpio_wr) begin
         gpio_out_reg <= pwdata[`GPIO_OUT_BIT];
         gpio_oe_reg  <= pwdata[`GPIO_OE_BIT];
      end
   end

   // System clock halved for the pin; runs only while clock-out is selected
   logic div2_reg;

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         div2_reg <= 1'b0;
      end else if (pin_clk_reg) begin
         div2_reg <= ~div2_reg; // R15
      end else begin
         div2_reg <= 1'b0;
      end
   end

   logic pin_out_reg;
   logic pin_oe_reg;
   wire  pin_out_next = pin_clk_reg ? ~div2_reg : gpio_out_reg;
   // Modes 10 and 01 leave the pin to the oscillator circuit
   wire  pin_oe_next  = pin_clk_reg | (pin_gpio_reg & gpio_oe_reg); // R15 R16 R17

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         pin_out_reg <= 1'b0;
         pin_oe_reg  <= 1'b0;
      end else begin
         pin_out_reg <= pin_gpio_reg | pin_clk_reg ? pin_out_next : 1'b0; // R16
         pin_oe_reg  <= pin_oe_next;
      end
   end

   // Read data captured in the setup phase, shown in the access phase
   logic [31:0] status_word;
   logic [31:0] rd_mux;
   logic [31:0] prdata_reg;
   logic        pslverr_next;

   always_comb begin
      status_word = `RST_WORD;
      status_word[`ST_SRC_LSB +: 3]    = src_reg;
      status_word[`ST_USE_PLL_BIT]     = pll_reg;
      status_word[`ST_POSTSCALE_BIT]   = post_reg;
      status_word[`ST_SRC_RSVD_BIT]    = rsvd_reg;
      status_word[`ST_TWO_SPEED_BIT]   = two_speed_reg;
      status_word[`ST_CLK_SW_BIT]      = sw_reg;
      status_word[`ST_MON_BIT]         = mon_reg;
      status_word[`ST_PIN_CLK_BIT]     = pin_clk_reg;
      status_word[`ST_PIN_GPIO_BIT]    = pin_gpio_reg;
      status_word[`ST_TWOWIRE_BIT]     = twowire_reg;
      status_word[`ST_ONE_WAY_BIT]     = one_way_reg;
      status_word[`ST_LOCK_BIT]        = lock_reg;
      status_word[`ST_ARMED_BIT]       = armed;
   end

   always_comb begin
      rd_mux = `RST_WORD;
      if (hit_cfg) begin
         rd_mux[CFG_WIDTH-1:0] = cfg_reg;
      end else if (hit_status) begin
         rd_mux = status_word;
      end else if (hit_lock) begin
         rd_mux[`LOCK_BIT] = lock_reg;
      end else if (hit_pps) begin
         rd_mux[PPS_WIDTH-1:0] = pps_reg;
      end else if (hit_gpio) begin
         rd_mux[`GPIO_OUT_BIT] = gpio_out_reg;
         rd_mux[`GPIO_OE_BIT]  = gpio_oe_reg;
         rd_mux[`GPIO_IN_BIT]  = osc_output_pin_in;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         prdata_reg <= `RST_WORD;
      end else if (apb_setup && !pwrite) begin
         prdata_reg <= rd_mux;
      end
   end

   // Unmapped addresses, read-only registers and refused lock or pin writes
   wire ro_write = pwrite & (hit_cfg | hit_status);
   always_comb begin
      pslverr_next = 1'b0;
      if (apb_access) begin
         pslverr_next = ~hit_any | ro_write | pps_refused | lock_refused;
      end
   end

   assign prdata                    = prdata_reg;
   assign pready                    = 1'b1;
   assign pslverr                   = pslverr_next;
   assign initial_osc_select        = src_reg;
   assign src_use_pll               = pll_reg;
   assign src_use_postscaler        = post_reg;
   assign src_reserved              = rsvd_reg;
   assign two_speed_startup_en      = two_speed_reg;
   assign clk_switch_en             = sw_reg;
   assign fail_safe_mon_en          = mon_reg;
   assign osc_output_pin_out        = pin_out_reg;
   assign osc_output_pin_oe         = pin_oe_reg;
   assign second_twowire_pin_choice = twowire_reg;
   assign pin_select_lock           = lock_reg;
   assign pin_select_value          = pps_reg;

endmodule : clock_config_word_decoder

`default_nettype wire

//--- tb/nv_config_source.sv
// Purpose: Config memory and pad model
// Assumes: Word set before reset release
// Notes:   Pad pulled up
`timescale 1ns/1ps
`default_nettype none
module nv_config_source (
   // Programmed word
   input  wire logic [23:0] prog_word,
   output logic      [23:0] cfg_word,
   // Oscillator-output pad
   input  wire logic        pin_drv,
   input  wire logic        pin_oe,
   output logic             pin_level
);
   assign cfg_word  = prog_word;
   // Released pin reads high
   assign pin_level = pin_oe ? pin_drv : 1'b1;
endmodule : nv_config_source
`default_nettype wire

//--- tb/clock_config_word_decoder_properties.sv
// Purpose: Port checks of the decoder
// Assumes: Synchronous reset on mclk
// Notes:   Word taken at first edge after release
`timescale 1ns/1ps
`default_nettype none
module clock_config_word_decoder_properties #(
   parameter int CFG_WIDTH = 24,
   parameter int PPS_WIDTH = 32
) (
   // Clock, reset, word
   input wire logic                 mclk,
   input wire logic                 nrst,
   input wire logic [CFG_WIDTH-1:0] cfg_word,
   // Bus
   input wire logic                 psel,
   input wire logic                 penable,
   input wire logic                 pwrite,
   input wire logic [11:0]          paddr,
   input wire logic [31:0]          pwdata,
   input wire logic                 pslverr,
   // Decoded outputs
   input wire logic [2:0]           initial_osc_select,
   input wire logic                 src_use_pll,
   input wire logic                 src_use_postscaler,
   input wire logic                 src_reserved,
   input wire logic                 two_speed_startup_en,
   input wire logic                 clk_switch_en,
   input wire logic                 fail_safe_mon_en,
   input wire logic                 osc_output_pin_out,
   input wire logic                 osc_output_pin_oe,
   input wire logic                 second_twowire_pin_choice,
   input wire logic                 pin_select_lock,
   input wire logic [PPS_WIDTH-1:0] pin_select_value
);
   logic [1:0]           up_cnt_reg;
   logic [CFG_WIDTH-1:0] word_reg;
   wire logic            settled = (up_cnt_reg == 2'h3);
   wire logic [2:0]      code    = word_reg[10:8];
   wire logic            honor   = (word_reg[1:0] == 2'h3) || (word_reg[1:0] == 2'h0);
   wire logic            bus_wr  = psel && penable && pwrite;
   // One edge past decode latency
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         up_cnt_reg <= 2'h0;
      end else if (!settled) begin
         up_cnt_reg <= up_cnt_reg + 2'h1;
      end
   end
   always_ff @(posedge mclk) begin
      if (nrst && up_cnt_reg == 2'h0) begin
         word_reg <= cfg_word;
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   sequence s_pin_clk;
      osc_output_pin_oe ##1 (osc_output_pin_oe && $changed(osc_output_pin_out));
   endsequence
   sequence s_lock_kept;
      pslverr ##1 pin_select_lock;
   endsequence
   a_osc_code: assert property (settled |-> initial_osc_select == code)
      else $error("source code differs from word");
   a_src_paths: assert property (settled |-> {src_use_pll, src_use_postscaler, src_reserved} ==
      {code == 3'h3 || code == 3'h1, code == 3'h7 || code == 3'h1, code == 3'h6})
      else $error("source path flags wrong");
   a_two_speed: assert property (settled |-> two_speed_startup_en == word_reg[15])
      else $error("two-speed start-up wrong");
   a_switch_mon: assert property (settled |-> clk_switch_en == !word_reg[7] &&
      fail_safe_mon_en == (word_reg[7:6] == 2'h0))
      else $error("switch or monitor enable wrong");
   a_twowire_pins: assert property (settled |-> second_twowire_pin_choice == word_reg[2])
      else $error("two-wire pin choice wrong");
   a_pin_clock: assert property (settled && honor && word_reg[5] |-> s_pin_clk)
      else $error("pin not toggling as clock");
   a_pin_ignored: assert property (settled && !honor |->
      !osc_output_pin_oe && !osc_output_pin_out)
      else $error("pin driven in ignored mode");
   a_locked_refuse: assert property (bus_wr && paddr == 12'h010 && pin_select_lock |->
      pslverr ##1 $stable(pin_select_value))
      else $error("locked pin-select write accepted");
   a_one_way_lock: assert property (settled && bus_wr && paddr == 12'h008 && word_reg[4] &&
      pin_select_lock && !pwdata[0] |-> s_lock_kept)
      else $error("one-way lock cleared");
   a_word_frozen: assert property (settled |=> $stable({initial_osc_select,
      two_speed_startup_en, fail_safe_mon_en, second_twowire_pin_choice}))
      else $error("decoded selection changed");
endmodule : clock_config_word_decoder_properties
bind clock_config_word_decoder clock_config_word_decoder_properties #(
   .CFG_WIDTH(CFG_WIDTH), .PPS_WIDTH(PPS_WIDTH)
) clock_config_word_decoder_properties_inst (
   .mclk, .nrst, .cfg_word, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr,
   .initial_osc_select, .src_use_pll, .src_use_postscaler, .src_reserved,
   .two_speed_startup_en, .clk_switch_en, .fail_safe_mon_en, .osc_output_pin_out,
   .osc_output_pin_oe, .second_twowire_pin_choice, .pin_select_lock, .pin_select_value
);
`default_nettype wire

//--- tb/clock_config_word_decoder_tb.sv
// Purpose: Self-checking decoder bench
// Assumes: Answer taken when pready is high
// Notes:   Each scenario reboots the block
`include "clock_config_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module clock_config_word_decoder_tb;
   logic            mclk      = 1'b0;
   logic            nrst      = 1'b0;
   logic            psel      = 1'b0;
   logic            penable   = 1'b0;
   logic            pwrite    = 1'b0;
   logic [11:0]     paddr     = 12'h000;
   logic [31:0]     pwdata    = 32'h0000_0000;
   logic [23:0]     prog_word = 24'h00_0000;
   wire logic [23:0] cfg_word;
   wire logic [31:0] prdata;
   wire logic       pready;
   wire logic       pslverr;
   wire logic [2:0] osc_sel;
   wire logic [6:0] flags;
   wire logic       pin_in;
   wire logic       pin_out;
   wire logic       pin_oe;
   wire logic       lock;
   wire logic [31:0] pps_value;
   int              errors    = 0;
   int              compares  = 0;
   int              cycles    = 0;
   clock_config_word_decoder clock_config_word_decoder_inst (
      .mclk(mclk), .nrst(nrst), .cfg_word(cfg_word), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .initial_osc_select(osc_sel), .src_use_pll(flags[6]),
      .src_use_postscaler(flags[5]), .src_reserved(flags[4]), .two_speed_startup_en(flags[3]),
      .clk_switch_en(flags[2]), .fail_safe_mon_en(flags[1]), .osc_output_pin_in(pin_in),
      .osc_output_pin_out(pin_out), .osc_output_pin_oe(pin_oe),
      .second_twowire_pin_choice(flags[0]), .pin_select_lock(lock), .pin_select_value(pps_value)
   );
   nv_config_source nv_config_source_inst (
      .prog_word(prog_word), .cfg_word(cfg_word), .pin_drv(pin_out), .pin_oe(pin_oe),
      .pin_level(pin_in)
   );
   always #2 mclk = ~mclk;
   always @(posedge mclk) begin
      cycles++;
      if (cycles > 20000) begin
         errors++;
         $display("Error at %0t: run timed out", $time);
         summarize();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic exp_err, output logic [31:0] rd);
      @(posedge mclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge mclk);
      penable <= 1'b1;
      // Settled answer, taken before the edge that ends the access
      do @(negedge mclk); while (pready !== 1'b1);
      rd = prdata;
      chk({31'h0, pslverr}, {31'h0, exp_err}, "error flag");
      @(posedge mclk);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic exp_err);
      logic [31:0] unused;
      apb(1'b1, a, d, exp_err, unused);
   endtask : wr
   task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
      logic [31:0] v;
      apb(1'b0, a, 32'h0000_0000, exp_err, v);
      if (!exp_err) chk(v, exp, "read data");
   endtask : rd
   task automatic unlock();
      wr(`OFF_UNLOCK_KEY, `UNLOCK_KEY1, 1'b0);
      wr(`OFF_UNLOCK_KEY, `UNLOCK_KEY2, 1'b0);
   endtask : unlock
   // Word held through reset and four edges after release
   task automatic boot(input logic [23:0] w);
      @(posedge mclk);
      prog_word <= w;
      nrst      <= 1'b0;
      repeat (3) @(posedge mclk);
      nrst <= 1'b1;
      repeat (4) @(posedge mclk);
   endtask : boot
   task automatic test_decode();
      logic [23:0] w;
      logic [2:0]  c;
      logic [9:0]  e;
      logic        hon;
      logic        prev;
      for (int i = 0; i < 32; i++) begin
         w = {3'h5, i[4:0], i[0], i[3:0], i[2:0], i[4:3], i[1], 2'h0, i[2], i[4:3]};
         c = w[10:8];
         e = {c, (c == 3'h3) || (c == 3'h1), (c == 3'h7) || (c == 3'h1), c == 3'h6,
              w[15], !w[7], w[7:6] == 2'h0, w[2]};
         boot(w);
         chk({22'h0, osc_sel, flags}, {22'h0, e}, "decode");
         hon  = (w[1:0] == 2'h3) || (w[1:0] == 2'h0);
         @(negedge mclk);
         prev = pin_out;
         @(negedge mclk);
         if (hon && w[5]) chk({pin_oe, pin_out}, {1'b1, !prev}, "clock pin");
         else chk({pin_oe, pin_out}, 2'h0, "idle pin");
         @(posedge mclk);
         prog_word <= ~w;
         repeat (3) @(posedge mclk);
         chk({22'h0, osc_sel, flags}, {22'h0, e}, "frozen decode");
      end
      $display("test decode done");
   endtask : test_decode
   task automatic test_pin_gpio();
      boot(24'h00_0000);
      wr(`OFF_GPIO_CTRL, 32'h0000_0003, 1'b0);
      repeat (2) @(posedge mclk);
      chk({pin_oe, pin_out}, 2'h3, "port drive");
      rd(`OFF_GPIO_CTRL, 32'h0000_0007, 1'b0);
      wr(`OFF_GPIO_CTRL, 32'h0000_0002, 1'b0);
      rd(`OFF_GPIO_CTRL, 32'h0000_0002, 1'b0);
      wr(`OFF_GPIO_CTRL, 32'h0000_0000, 1'b0);
      rd(`OFF_GPIO_CTRL, 32'h0000_0004, 1'b0);
      $display("test pin gpio done");
   endtask : test_pin_gpio
   task automatic test_lock(input logic one_way);
      boot({19'h0_0000, one_way, 4'h0});
      wr(`OFF_PIN_SELECT, 32'h1234_5678, 1'b0);
      wr(`OFF_LOCK_CTRL, 32'h0000_0001, 1'b1);
      rd(`OFF_LOCK_CTRL, 32'h0000_0000, 1'b0);
      unlock();
      wr(`OFF_LOCK_CTRL, 32'h0000_0001, 1'b0);
      wr(`OFF_PIN_SELECT, 32'hFFFF_0000, 1'b1);
      rd(`OFF_PIN_SELECT, 32'h1234_5678, 1'b0);
      chk(pps_value, 32'h1234_5678, "pin-select value");
      unlock();
      wr(`OFF_LOCK_CTRL, 32'h0000_0000, one_way);
      rd(`OFF_LOCK_CTRL, {31'h0, one_way}, 1'b0);
      chk({31'h0, lock}, {31'h0, one_way}, "lock pin");
      unlock();
      wr(`OFF_LOCK_CTRL, 32'h0000_0001, 1'b0);
      rd(`OFF_LOCK_CTRL, 32'h0000_0001, 1'b0);
      $display("test lock done");
   endtask : test_lock
   task automatic test_bus();
      boot(24'hA5_5A3C);
      rd(`OFF_CFG_WORD, 32'h00A5_5A3C, 1'b0);
      wr(`OFF_CFG_WORD, 32'h0000_0000, 1'b1);
      wr(`OFF_DECODE_STATUS, 32'h0000_0000, 1'b1);
      rd(12'h018, 32'h0000_0000, 1'b1);
      rd(`OFF_UNLOCK_KEY, 32'h0000_0000, 1'b0);
      // Broken key pair must not arm the lock
      wr(`OFF_UNLOCK_KEY, `UNLOCK_KEY1, 1'b0);
      wr(`OFF_PIN_SELECT, 32'h0000_00A5, 1'b0);
      wr(`OFF_UNLOCK_KEY, `UNLOCK_KEY2, 1'b0);
      wr(`OFF_LOCK_CTRL, 32'h0000_0001, 1'b1);
      $display("test bus done");
   endtask : test_bus
   task automatic summarize();
      $display("Comparisons %0d, mismatches %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : summarize
   initial begin
      repeat (20) @(posedge mclk);
      nrst <= 1'b1;
      test_decode();
      test_pin_gpio();
      test_lock(1'b0);
      test_lock(1'b1);
      test_bus();
      summarize();
   end
endmodule : clock_config_word_decoder_tb
`default_nettype wire
